// ---- design/cfpf_top.sv ----
// eighteen bit clocked fifo with programmable flags and parity
`include "cfpf_defs.svh"

module cfpf_top #(
	parameter int DEPTH = `CFPF_DEPTH_DEF,
	parameter int AW = $clog2(DEPTH),
	parameter int PW = AW + 1
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire cfpf_pkg::cfpf_word_t i_d,
	input wire logic i_wr_clk,
	input wire logic i_wr_en_n,
	input wire logic i_rd_clk,
	input wire logic i_rd_en_n,
	input wire logic i_master_rst_n,
	input wire logic i_first_load_n,
	input wire logic i_cascade_in_n,
	input wire logic i_oe_n,
	output cfpf_pkg::cfpf_word_t o_q,
	output logic o_q_oe_n,
	output logic o_half_full_flag_n,
	output logic o_empty_full_n,
	output logic o_almost_flag_n
);
	import cfpf_pkg::*;

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam logic [AW+1:0] DEPTH_C = (AW+2)'(DEPTH);
	localparam logic [AW:0] HALF_C = (AW+1)'(DEPTH / 2);
	localparam logic [AW:0] FULL_C = (AW+1)'(DEPTH);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr_clk_q;
		logic rd_clk_q;
		logic mr_q;
		logic rt_q;
		logic [AW:0] wptr;
		logic [AW:0] rptr;
		cfpf_word_t prog;
		logic full;
		logic afull;
		logic hfull;
		logic empty;
		logic aempty;
		logic casc;
		logic wr_tok;
		logic rd_tok;
		logic xo_n;
		logic rd_pend;
		cfpf_word_t q;
		logic ef_n;
		logic almost_flag_n;
		logic hf_n;
	} cfpf_state_t;

	localparam cfpf_state_t ST_RST = '{
		wr_clk_q: 1'b0,
		rd_clk_q: 1'b0,
		mr_q: 1'b1,
		rt_q: 1'b1,
		wptr: '0,
		rptr: '0,
		prog: `CFPF_PROG_DEF,
		full: 1'b0,
		afull: 1'b0,
		hfull: 1'b0,
		empty: 1'b1,
		aempty: 1'b1,
		casc: 1'b0,
		wr_tok: 1'b1,
		rd_tok: 1'b1,
		xo_n: 1'b1,
		rd_pend: 1'b0,
		q: '0,
		ef_n: 1'b0,
		almost_flag_n: 1'b0,
		hf_n: 1'b1
	};

	cfpf_state_t state_ff;
	cfpf_state_t nxt_state;

	cfpf_mem_if #(.AW(AW)) mem_bus ();

	// ----------------------------------------------------------------
	// edge detection and qualifiers
	// ----------------------------------------------------------------
	logic wr_edge;
	logic rd_edge;
	logic mr_act;
	logic mr_fall;
	logic rt_strobe;
	logic wr_go;
	logic rd_go;
	logic prog_wr;
	logic prog_rd;
	logic [PW-1:0] offset;
	cfpf_par_t par_mode;
	logic par_odd;
	cfpf_word_t wr_word;
	cfpf_word_t rd_word;
	logic [AW:0] cnt_w;
	logic [AW:0] cnt_r;

	assign mr_act = ~i_master_rst_n;
	assign mr_fall = mr_act & state_ff.mr_q;
	assign offset = state_ff.prog[PW-1:0];
	assign par_odd = state_ff.prog[`CFPF_CFG_PAR_ODD_BIT];

	assign wr_edge = i_wr_clk & ~state_ff.wr_clk_q & ~i_wr_en_n;
	assign rd_edge = i_rd_clk & ~state_ff.rd_clk_q & ~i_rd_en_n;

	assign rt_strobe = ~state_ff.casc & ~i_first_load_n & state_ff.rt_q
		& ~mr_act;

	assign wr_go = wr_edge & ~mr_act & ~state_ff.full & state_ff.wr_tok;
	assign rd_go = rd_edge & ~mr_act & ~state_ff.empty & state_ff.rd_tok;
	assign prog_wr = wr_edge & mr_act;
	assign prog_rd = rd_edge & mr_act;

	always_comb begin
		if (!state_ff.prog[`CFPF_CFG_PAR_EN_BIT]) begin
			par_mode = CFPF_PAR_NONE;
		end else if (state_ff.prog[`CFPF_CFG_PAR_CHK_BIT]) begin
			par_mode = CFPF_PAR_CHK;
		end else begin
			par_mode = CFPF_PAR_GEN;
		end
	end

	// ----------------------------------------------------------------
	// parity on the write and read side
	// ----------------------------------------------------------------
	always_comb begin
		wr_word = i_d;
		if (par_mode == CFPF_PAR_GEN) begin
			wr_word[`CFPF_PAR_LO_BIT] = (^i_d[7:0]) ^ par_odd;
			wr_word[`CFPF_PAR_HI_BIT] = (^i_d[16:9]) ^ par_odd;
		end
	end

	always_comb begin
		rd_word = mem_bus.rd_data;
		if (par_mode == CFPF_PAR_CHK) begin
			rd_word[`CFPF_PAR_LO_BIT] = ((^mem_bus.rd_data[8:0]) == par_odd);
			rd_word[`CFPF_PAR_HI_BIT] = ((^mem_bus.rd_data[17:9]) == par_odd);
		end
	end

	// ----------------------------------------------------------------
	// memory access
	// ----------------------------------------------------------------
	assign mem_bus.wr_en = wr_go;
	assign mem_bus.wr_addr = state_ff.wptr[AW-1:0];
	assign mem_bus.wr_data = wr_word;
	assign mem_bus.rd_en = rd_go;
	assign mem_bus.rd_addr = state_ff.rptr[AW-1:0];

	cfpf_mem #(.AW(AW)) u_mem (
		.i_sys_clk(i_sys_clk),
		.m(mem_bus.mem)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;

		// ----------------------------------------
		// pin history
		// ----------------------------------------
		nxt_state.wr_clk_q = i_wr_clk;
		nxt_state.rd_clk_q = i_rd_clk;
		nxt_state.mr_q = i_master_rst_n;
		nxt_state.rt_q = i_first_load_n;
		nxt_state.rd_pend = rd_go;

		// ----------------------------------------
		// pointers
		// ----------------------------------------
		if (wr_go) begin
			nxt_state.wptr = state_ff.wptr + 1'b1;
		end
		if (rd_go) begin
			nxt_state.rptr = state_ff.rptr + 1'b1;
		end
		if (rt_strobe) begin
			nxt_state.rptr = '0;
		end

		cnt_w = nxt_state.wptr - state_ff.rptr;
		cnt_r = state_ff.wptr - nxt_state.rptr;

		// ----------------------------------------
		// write side flags
		// ----------------------------------------
		// write side flags
		if (wr_edge) begin
			nxt_state.full = (cnt_w == FULL_C);
			nxt_state.hfull = (cnt_w > HALF_C);
			nxt_state.afull = ({1'b0, cnt_w} + {1'b0, offset}) >= DEPTH_C;
		end
		// ----------------------------------------
		// read side flags
		// ----------------------------------------
		// read side flags
		if (rd_edge || rt_strobe) begin
			nxt_state.empty = (cnt_r == '0);
			nxt_state.aempty = (cnt_r <= offset);
		end

		// ----------------------------------------
		// cascade tokens
		// ----------------------------------------
		// cascade token passing
		if (state_ff.casc) begin
			if (wr_edge || rd_edge) begin
				nxt_state.xo_n = 1'b1;
			end
			if (wr_go && cnt_w == FULL_C) begin
				nxt_state.wr_tok = 1'b0;
				nxt_state.xo_n = 1'b0;
			end else if (wr_edge && !state_ff.wr_tok && !i_cascade_in_n) begin
				nxt_state.wr_tok = 1'b1;
			end
			if (rd_go && cnt_r == '0) begin
				nxt_state.rd_tok = 1'b0;
				nxt_state.xo_n = 1'b0;
			end else if (rd_edge && !state_ff.rd_tok && !i_cascade_in_n) begin
				nxt_state.rd_tok = 1'b1;
			end
		end

		// ----------------------------------------
		// output word
		// ----------------------------------------
		// registered read data
		if (state_ff.rd_pend) begin
			nxt_state.q = rd_word;
		end

		// ----------------------------------------
		// master reset
		// ----------------------------------------
		// master reset empties
		if (mr_act) begin
			nxt_state.wptr = '0;
			nxt_state.rptr = '0;
			nxt_state.full = 1'b0;
			nxt_state.afull = 1'b0;
			nxt_state.hfull = 1'b0;
			nxt_state.empty = 1'b1;
			nxt_state.aempty = 1'b1;
			nxt_state.xo_n = 1'b1;
			nxt_state.casc = ~i_first_load_n | i_cascade_in_n;
			if (i_first_load_n ^ nxt_state.casc) begin
				nxt_state.wr_tok = 1'b1;
			end else begin
				nxt_state.wr_tok = ~i_first_load_n;
			end
			nxt_state.rd_tok = nxt_state.wr_tok;
			if (mr_fall) begin
				nxt_state.prog = `CFPF_PROG_DEF;
			end
			if (prog_wr) begin
				nxt_state.prog = '0;
				nxt_state.prog[PW-1:0] = i_d[PW-1:0];
				nxt_state.prog[17:15] = i_d[17:15];
			end
			if (prog_rd) begin
				nxt_state.q = state_ff.prog;
			end
		end

		// ----------------------------------------
		// pin flags
		// ----------------------------------------
		// shared empty or full
		nxt_state.ef_n = ~(nxt_state.empty | nxt_state.full);
		nxt_state.hf_n = ~nxt_state.hfull;
		if (nxt_state.casc) begin
			nxt_state.almost_flag_n = nxt_state.xo_n;
		end else begin
			nxt_state.almost_flag_n = ~(nxt_state.aempty | nxt_state.afull);
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state_ff <= ST_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_q = state_ff.q;
	assign o_q_oe_n = i_oe_n;
	assign o_half_full_flag_n = state_ff.hf_n;
	assign o_empty_full_n = state_ff.ef_n;
	assign o_almost_flag_n = state_ff.almost_flag_n;

endmodule : cfpf_top

// ---- pkg/cfpf_defs.svh ----
// offsets, field positions and reset values of the clocked fifo
`ifndef CFPF_DEFS_SVH
`define CFPF_DEFS_SVH

// ----------------------------------------------------------------
// depth and data word
// ----------------------------------------------------------------
`define CFPF_DEPTH_DEF 512
`define CFPF_WORD_W 18

// ----------------------------------------------------------------
// parity positions in the data word
// ----------------------------------------------------------------
`define CFPF_PAR_LO_BIT 8
`define CFPF_PAR_HI_BIT 17

// ----------------------------------------------------------------
// program_config fields
// ----------------------------------------------------------------
`define CFPF_CFG_PAR_EN_BIT 15
`define CFPF_CFG_PAR_CHK_BIT 16
`define CFPF_CFG_PAR_ODD_BIT 17
`define CFPF_ALMOST_DEF 16
`define CFPF_PROG_DEF 18'h00010

`endif

// ---- pkg/cfpf_pkg.sv ----
// types shared by the clocked fifo modules
package cfpf_pkg;

	// ----------------------------------------------------------------
	// data word and parity mode
	// ----------------------------------------------------------------
	typedef logic [17:0] cfpf_word_t;

	typedef enum logic [2:0] {
		CFPF_PAR_NONE = 3'b001,
		CFPF_PAR_GEN = 3'b010,
		CFPF_PAR_CHK = 3'b100
	} cfpf_par_t;

endpackage : cfpf_pkg

// ---- pkg/cfpf_mem_if.sv ----
// interface between the fifo control and its memory
interface cfpf_mem_if #(parameter int AW = 9) ();
	logic wr_en;
	logic [AW-1:0] wr_addr;
	cfpf_pkg::cfpf_word_t wr_data;
	logic rd_en;
	logic [AW-1:0] rd_addr;
	cfpf_pkg::cfpf_word_t rd_data;

	modport ctrl (
		output wr_en, wr_addr, wr_data, rd_en, rd_addr,
		input rd_data
	);
	modport mem (
		input wr_en, wr_addr, wr_data, rd_en, rd_addr,
		output rd_data
	);
endinterface : cfpf_mem_if

// ---- design/cfpf_mem.sv ----
// fifo word memory with registered read data
module cfpf_mem #(
	parameter int AW = 9
) (
	input wire logic i_sys_clk,
	cfpf_mem_if.mem m
);
	import cfpf_pkg::*;

	localparam int DEPTH = 1 << AW;

	cfpf_word_t mem_ff [DEPTH];
	cfpf_word_t rd_data_ff;

	// ----------------------------------------------------------------
	// write port and registered read port
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (m.wr_en) begin
			mem_ff[m.wr_addr] <= m.wr_data;
		end
		if (m.rd_en) begin
			rd_data_ff <= mem_ff[m.rd_addr];
		end
	end

	assign m.rd_data = rd_data_ff;

endmodule : cfpf_mem

// ---- test/cfpf_properties.sv ----
// port assertions for the clocked fifo
module cfpf_properties #(
	parameter int PW = 10
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_wr_clk,
	input wire logic i_rd_clk,
	input wire logic i_rd_en_n,
	input wire logic i_master_rst_n,
	input wire logic i_first_load_n,
	input wire logic i_cascade_in_n,
	input wire logic i_oe_n,
	input wire cfpf_pkg::cfpf_word_t o_q,
	input wire logic o_q_oe_n,
	input wire logic o_half_full_flag_n,
	input wire logic o_empty_full_n,
	input wire logic o_almost_flag_n
);
	timeunit 1ns;
	timeprecision 100ps;
	import cfpf_pkg::*;
	logic wr_q_ff, rd_q_ff, wr_rise, rd_rise;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_sys_rst);
	always_ff @(posedge i_sys_clk) begin
		wr_q_ff <= i_sys_rst ? 1'b0 : i_wr_clk;
		rd_q_ff <= i_sys_rst ? 1'b0 : i_rd_clk;
	end
	assign wr_rise = i_wr_clk & ~wr_q_ff;
	assign rd_rise = i_rd_clk & ~rd_q_ff;
	sequence s_mr_held;
		!i_master_rst_n [*3];
	endsequence
	sequence s_prog_rd;
		!i_master_rst_n && !i_rd_en_n && rd_rise;
	endsequence
	a_oe_follow:
		assert property (o_q_oe_n == i_oe_n) else $error("oe mismatch");
	a_hf_wr_side:
		assert property ($changed(o_half_full_flag_n) |-> $past(wr_rise)
			|| !$past(i_master_rst_n) || !$past(i_master_rst_n, 2))
			else $error("half full moved");
	a_ef_rise_cause:
		assert property ($rose(o_empty_full_n) |-> $past(rd_rise)
			|| $past(wr_rise) || !$past(i_first_load_n)
			|| !$past(i_first_load_n, 2)) else $error("flag rose");
	a_empty_holds:
		assert property (!o_empty_full_n && o_half_full_flag_n && !rd_rise
			&& i_master_rst_n && i_first_load_n && $past(i_first_load_n)
			|=> !o_empty_full_n) else $error("empty lost");
	a_full_holds:
		assert property (!o_empty_full_n && !o_half_full_flag_n && !wr_rise
			&& i_master_rst_n && i_first_load_n |=> !o_empty_full_n)
			else $error("full lost");
	a_mr_empties:
		assert property (s_mr_held |-> !o_empty_full_n && o_half_full_flag_n)
			else $error("not emptied");
	a_prog_zeros:
		assert property (s_prog_rd |=> o_q[14:PW] == '0)
			else $error("program bits set");
	a_almost_std:
		assert property (!o_empty_full_n && !i_cascade_in_n && i_first_load_n
			|-> !o_almost_flag_n) else $error("almost flag high");
endmodule : cfpf_properties

bind cfpf_top cfpf_properties #(.PW(PW)) u_props (.i_sys_clk, .i_sys_rst,
	.i_wr_clk, .i_rd_clk, .i_rd_en_n, .i_master_rst_n, .i_first_load_n,
	.i_cascade_in_n, .i_oe_n, .o_q, .o_q_oe_n, .o_half_full_flag_n,
	.o_empty_full_n, .o_almost_flag_n);

// ---- test/cfpf_peer.sv ----
// writer and reader model for the fifo ports
module cfpf_peer (
	input wire logic i_sys_clk,
	input wire logic i_ring_n,
	output cfpf_pkg::cfpf_word_t o_d,
	output logic o_wr_clk,
	output logic o_wr_en_n,
	output logic o_rd_clk,
	output logic o_rd_en_n,
	output logic o_first_load_n,
	output logic o_cascade_in_n
);
	timeunit 1ns;
	timeprecision 100ps;
	import cfpf_pkg::*;
	logic ring_on;
	// tied low, or own output in a ring
	assign o_cascade_in_n = ring_on ? i_ring_n : 1'b0;
	initial begin
		o_d = '0;
		o_wr_clk = 1'b0;
		o_wr_en_n = 1'b1;
		o_rd_clk = 1'b0;
		o_rd_en_n = 1'b1;
		o_first_load_n = 1'b1;
		ring_on = 1'b0;
	end
	task automatic step();
		@(posedge i_sys_clk);
		#1;
	endtask : step
	task automatic put(input cfpf_word_t w);
		step();
		o_wr_en_n = 1'b0;
		o_d = w;
		step();
		o_wr_clk = 1'b1;
		step();
		o_wr_clk = 1'b0;
		o_wr_en_n = 1'b1;
		o_d = ~w;
	endtask : put
	task automatic get();
		step();
		o_rd_en_n = 1'b0;
		step();
		o_rd_clk = 1'b1;
		step();
		o_rd_clk = 1'b0;
		o_rd_en_n = 1'b1;
	endtask : get
	task automatic tick();
		step();
		o_wr_clk = 1'b1;
		o_rd_clk = 1'b1;
		step();
		o_wr_clk = 1'b0;
		o_rd_clk = 1'b0;
	endtask : tick
	// first device of a chain holds it low
	task automatic chain(input logic on);
		ring_on = on;
		o_first_load_n = ~on;
	endtask : chain
	task automatic rewind();
		step();
		o_first_load_n = 1'b0;
		step();
		o_first_load_n = 1'b1;
	endtask : rewind
endmodule : cfpf_peer

// ---- test/tb.sv ----
// self checking bench for the clocked fifo
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import cfpf_pkg::*;
	localparam int DEPTH = 512;
	logic i_sys_clk, i_sys_rst, i_master_rst_n, i_oe_n, i_first_load_n;
	logic i_wr_clk, i_wr_en_n, i_rd_clk, i_rd_en_n, i_cascade_in_n;
	logic o_q_oe_n, o_half_full_flag_n, o_empty_full_n, o_almost_flag_n;
	cfpf_word_t i_d, o_q;
	int err_count, total_checks;
	cfpf_top #(.DEPTH(DEPTH)) u_dut (.i_sys_clk, .i_sys_rst, .i_d, .i_wr_clk,
		.i_wr_en_n, .i_rd_clk, .i_rd_en_n, .i_master_rst_n, .i_first_load_n,
		.i_cascade_in_n, .i_oe_n, .o_q, .o_q_oe_n, .o_half_full_flag_n,
		.o_empty_full_n, .o_almost_flag_n);
	cfpf_peer u_peer (.i_sys_clk, .i_ring_n(o_almost_flag_n),
		.o_d(i_d), .o_wr_clk(i_wr_clk),
		.o_wr_en_n(i_wr_en_n), .o_rd_clk(i_rd_clk), .o_rd_en_n(i_rd_en_n),
		.o_first_load_n(i_first_load_n), .o_cascade_in_n(i_cascade_in_n));
	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	task automatic check(input cfpf_word_t got, input cfpf_word_t exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic flags(input logic [2:0] exp);
		check({15'h0, o_half_full_flag_n, o_empty_full_n, o_almost_flag_n},
			{15'h0, exp});
	endtask : flags
	task automatic rd_chk(input cfpf_word_t exp);
		u_peer.get();
		u_peer.step();
		check(o_q, exp);
	endtask : rd_chk
	task automatic mreset(input logic prog, input cfpf_word_t w);
		u_peer.step();
		i_master_rst_n = 1'b0;
		repeat (3) u_peer.step();
		flags(3'h4); // emptied
		if (prog) u_peer.put(w); // program write
		rd_chk(prog ? w & 18'h383ff : 18'h00010); // readback
		i_master_rst_n = 1'b1;
	endtask : mreset
	task automatic t_idle();
		flags(3'h4); // empty
		check(o_q, '0); // nothing read yet
		i_oe_n = 1'b1;
		u_peer.step();
		check({17'h0, o_q_oe_n}, 18'h1); // outputs off
		i_oe_n = 1'b0;
		$display("idle end");
	endtask : t_idle
	task automatic t_stream();
		cfpf_word_t w[3] = '{18'h3ff00, 18'h00100, 18'h20055};
		u_peer.put(w[0]);
		u_peer.tick(); // disabled clocks
		u_peer.put(w[1]);
		u_peer.put(w[2]);
		flags(3'h4); // still empty
		rd_chk('0); // refused
		flags(3'h6); // cleared
		foreach (w[i]) rd_chk(w[i]); // order
		$display("stream end");
	endtask : t_stream
	task automatic t_parity();
		cfpf_word_t cfg[2] = '{18'h08004, 18'h18004};
		cfpf_word_t din[2] = '{18'h10001, 18'h20101};
		cfpf_word_t exp[2] = '{18'h30101, 18'h00101};
		for (int i = 0; i < 2; i++) begin
			mreset(1'b1, cfg[i]); // fields
			u_peer.put(din[i]);
			u_peer.get();
			rd_chk(exp[i]); // parity
		end
		$display("parity end");
	endtask : t_parity
	task automatic t_full();
		mreset(1'b0, '0); // defaults
		for (int i = 0; i < DEPTH; i++) u_peer.put(cfpf_word_t'(i + 5));
		flags(3'h0); // full
		u_peer.put(18'h3ffff);
		u_peer.get();
		rd_chk(18'h00005); // first word
		rd_chk(18'h00006); // second word
		flags(3'h0); // held
		u_peer.put(18'h2aaaa);
		flags(3'h2); // cleared
		$display("full end");
	endtask : t_full
	task automatic t_casc();
		u_peer.step();
		i_master_rst_n = 1'b0;
		u_peer.chain(1'b1); // single device chain
		repeat (2) u_peer.step();
		flags(3'h5); // expansion out idle
		i_master_rst_n = 1'b1;
		u_peer.put(18'h00777);
		u_peer.put(18'h10888);
		u_peer.get();
		rd_chk(18'h00777); // cascaded read
		flags(3'h7); // no pulse yet
		rd_chk(18'h10888); // last word
		flags(3'h4); // pulse on emptying read
		u_peer.get();
		flags(3'h5); // ring returns token
		u_peer.put(18'h00999);
		u_peer.get();
		u_peer.chain(1'b0);
		mreset(1'b0, '0); // standalone again
		$display("cascade end");
	endtask : t_casc
	task automatic t_retx();
		mreset(1'b0, '0);
		u_peer.put(18'h01234);
		u_peer.put(18'h2abcd);
		u_peer.get();
		rd_chk(18'h01234); // stored
		rd_chk(18'h2abcd); // order
		u_peer.rewind(); // strobe
		rd_chk(18'h01234); // rewound
		$display("retransmit end");
	endtask : t_retx
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	initial begin
		err_count = 0;
		total_checks = 0;
		i_sys_rst = 1'b1;
		i_master_rst_n = 1'b1;
		i_oe_n = 1'b0;
		repeat (4) @(posedge i_sys_clk);
		#1;
		i_sys_rst = 1'b0;
		t_idle();
		t_stream();
		t_parity();
		t_full();
		t_casc();
		t_retx();
		end_of_test();
	end
	initial begin
		repeat (6000) @(posedge i_sys_clk);
		err_count++;
		$display("unexpected at %0t: watchdog", $time);
		end_of_test();
	end
endmodule : tb
